// ---- hw/twowire_target.v ----
// two-wire target: command strobes, acknowledge reply, status flags and
// own-address match, behind an apb slave.
// assumes an external open-drain wire resolution for scl and sda and a
// system clock at least four times the scl rate.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "twowire_target_consts.vh"

module twowire_target #(
  parameter AW = 12
) (
  // clock and reset
  input  wire          clk,
  input  wire          rst_n,
  // apb slave
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [AW-1:0] paddr,
  input  wire [31:0]   pwdata,
  output reg  [31:0]   prdata,
  output wire          pready,
  output wire          pslverr,
  // two-wire pins, open drain
  input  wire          scl_in,
  output wire          scl_out,
  output reg           scl_oe,
  input  wire          sda_in,
  output wire          sda_out,
  output wire          sda_oe
);

  localparam S_IDLE = 3'd0;
  localparam S_ADDR = 3'd1;
  localparam S_HOLD = 3'd2;
  localparam S_ACK  = 3'd3;
  localparam S_RX   = 3'd4;
  localparam S_TX   = 3'd5;
  localparam S_MACK = 3'd6;
  localparam S_WAIT = 3'd7;

  function hit;
    input [AW-1:0] a;
    input [7:0]    idx;
    begin
      hit = (a == {{(AW-10){1'b0}}, idx, 2'b00});
    end
  endfunction

  // software registers
  reg  [7:0] control_a;
  reg        ack_reply_select;
  reg  [7:0] target_own_address;
  reg        controller_enable;
  reg  [7:0] target_shift_byte;

  // status
  reg        byte_done_flag;
  reg        addr_stop_flag;
  reg        master_ack_seen;
  reg        tx_clash_flag;
  reg        bus_fault_flag;
  reg        dir;
  reg        flag_cause;

  // bus engine
  reg  [2:0] state;
  reg  [3:0] bit_cnt;
  reg        hold_addr;
  reg        drive_low;
  reg  [1:0] after_ack;
  reg        ack_sent_nack;

  // synchronisers
  reg        scl_m;
  reg        scl_s;
  reg        scl_q;
  reg        sda_m;
  reg        sda_s;
  reg        sda_q;

  wire stop_irq_enable  = control_a[`CTLA_STOP_IRQ_EN];
  wire promisc          = control_a[`CTLA_PROMISC];
  wire auto_resume_mode = control_a[`CTLA_AUTO_RESUME];
  wire target_enable    = control_a[`CTLA_ENABLE];

  // apb decode
  wire wr_en    = psel & penable & pwrite;
  wire rd_en    = psel & penable & ~pwrite;
  wire hit_ca   = hit(paddr, `IDX_CONTROL_A);
  wire hit_cb   = hit(paddr, `IDX_CONTROL_B);
  wire hit_st   = hit(paddr, `IDX_STATUS);
  wire hit_ad   = hit(paddr, `IDX_OWN_ADDRESS);
  wire hit_dt   = hit(paddr, `IDX_SHIFT_BYTE);
  wire hit_cc   = hit(paddr, `IDX_CONTROLLER_CTL);
  wire mapped   = hit_ca | hit_cb | hit_st | hit_ad | hit_dt | hit_cc;

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  // once a clash is seen the target stops pulling sda low
  assign sda_oe  = drive_low & ~tx_clash_flag;

  wire [1:0] target_command_strobe = pwdata[`CTLB_CMD_HI:`CTLB_CMD_LO];
  wire       cmd_wr     = wr_en & hit_cb;
  wire       cmd_resp   = cmd_wr & (target_command_strobe == `CMD_RESPONSE);
  wire       cmd_comp   = cmd_wr & (target_command_strobe == `CMD_COMPLETE);
  // ack choice of this very write applies to its own command
  wire       ack_eff    = cmd_wr ? pwdata[`CTLB_ACK_SEL] : ack_reply_select;
  wire       data_rd    = rd_en & hit_dt;
  wire       data_wr    = wr_en & hit_dt;
  // without auto-resume a data access neither resumes nor clears the flags
  wire       data_go    = auto_resume_mode & (data_rd | data_wr);
  wire       acc_clear  = cmd_resp | cmd_comp | data_go;
  wire       holding    = (state == S_HOLD);
  wire       resume     = holding & (cmd_resp | data_go);
  wire       complete   = holding & cmd_comp & ~cmd_resp;
  wire       data_wr_ok = data_wr & (holding | state == S_IDLE | state == S_WAIT);

  // bus events, never from the first synchroniser stage
  wire scl_rise = scl_s & ~scl_q;
  wire scl_fall = ~scl_s & scl_q;
  wire start_ev = scl_s & scl_q & sda_q & ~sda_s;
  wire stop_ev  = scl_s & scl_q & ~sda_q & sda_s;
  wire in_byte  = (state == S_ADDR) | (state == S_RX) | (state == S_TX);
  // first scl pulse of a legal stop or repeated start counts as bit one
  wire mid_byte = (state == S_TX) ? (bit_cnt != 4'h0) : (in_byte & bit_cnt > 4'h1);

  wire [6:0] rx_addr   = target_shift_byte[7:1];
  wire       addr_hit  = promisc | (rx_addr == target_own_address[7:1]) |
                         (target_own_address[0] & (rx_addr == 7'h00));

  // w1c masks from a status write
  wire       st_wr     = wr_en & hit_st;
  wire       w1c_done  = st_wr & pwdata[`ST_BYTE_DONE];
  wire       w1c_addr  = st_wr & pwdata[`ST_ADDR_STOP];
  wire       w1c_clash = st_wr & pwdata[`ST_CLASH];
  wire       w1c_fault = st_wr & pwdata[`ST_BUS_FAULT];

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_q <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_m <= scl_in;
      scl_s <= scl_m;
      scl_q <= scl_s;
      sda_m <= sda_in;
      sda_s <= sda_m;
      sda_q <= sda_s;
    end
  end

  // plain software registers
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      control_a          <= `RST_REG8;
      ack_reply_select   <= 1'b0;
      target_own_address <= `RST_REG8;
      controller_enable  <= 1'b0;
    end else if (wr_en) begin
      if (hit_ca) begin
        control_a <= pwdata[7:0] & 8'he7;
      end else if (hit_cb) begin
        ack_reply_select <= pwdata[`CTLB_ACK_SEL];
      end else if (hit_ad) begin
        target_own_address <= pwdata[7:0];
      end else if (hit_cc) begin
        controller_enable <= pwdata[`CCTL_ENABLE];
      end
    end
  end

  // bus engine and status flags; sets are written last so they win
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state             <= S_IDLE;
      bit_cnt           <= 4'h0;
      hold_addr         <= 1'b0;
      drive_low         <= 1'b0;
      after_ack         <= `AFT_RX;
      ack_sent_nack     <= 1'b0;
      scl_oe            <= 1'b0;
      target_shift_byte <= `RST_REG8;
      byte_done_flag    <= 1'b0;
      addr_stop_flag    <= 1'b0;
      master_ack_seen   <= 1'b0;
      tx_clash_flag     <= 1'b0;
      bus_fault_flag    <= 1'b0;
      dir               <= 1'b0;
      flag_cause        <= 1'b0;
    end else begin
      // scl is let go on the same edge that sets sda
      scl_oe <= holding & ~resume & ~complete;
      if (acc_clear | w1c_done) begin
        byte_done_flag <= 1'b0;
      end
      if (acc_clear | w1c_addr) begin
        addr_stop_flag <= 1'b0;
      end
      if (w1c_clash | start_ev) begin
        tx_clash_flag <= 1'b0;
      end
      if (w1c_fault) begin
        bus_fault_flag <= 1'b0;
      end
      if (data_wr_ok) begin
        target_shift_byte <= pwdata[7:0];
      end
      // misplaced start or stop, seen only with the controller enabled
      if (controller_enable & (start_ev | stop_ev) &
          ((state == S_ADDR & bit_cnt <= 4'h1 & stop_ev) | mid_byte)) begin
        bus_fault_flag <= 1'b1;
      end
      if (!target_enable) begin
        state     <= S_IDLE;
        drive_low <= 1'b0;
      end else if (start_ev) begin
        state     <= S_ADDR;
        bit_cnt   <= 4'h0;
        drive_low <= 1'b0;
      end else if (stop_ev) begin
        if (stop_irq_enable & state != S_IDLE) begin
          addr_stop_flag <= 1'b1;
          flag_cause     <= 1'b0;
        end
        state     <= S_IDLE;
        drive_low <= 1'b0;
      end else begin
        case (state)
          S_ADDR, S_RX: begin
            if (scl_rise & bit_cnt != 4'h8) begin
              target_shift_byte <= {target_shift_byte[6:0], sda_s};
              bit_cnt           <= bit_cnt + 4'h1;
            end else if (scl_fall & bit_cnt == 4'h8) begin
              bit_cnt <= 4'h0;
              if (state == S_RX) begin
                byte_done_flag <= 1'b1;
                hold_addr      <= 1'b0;
                state          <= S_HOLD;
              end else if (addr_hit) begin
                addr_stop_flag <= 1'b1;
                flag_cause     <= 1'b1;
                dir            <= target_shift_byte[0];
                hold_addr      <= 1'b1;
                state          <= S_HOLD;
              end else begin
                state <= S_IDLE;
              end
            end
          end
          S_HOLD: begin
            // hold line low until a response or complete command or an auto-resume access
            if (resume) begin
              if (!dir) begin
                drive_low     <= ~ack_eff;
                ack_sent_nack <= ack_eff;
                after_ack     <= `AFT_RX;
                state         <= S_ACK;
              end else if (hold_addr) begin
                drive_low     <= ~ack_eff;
                ack_sent_nack <= ack_eff;
                after_ack     <= `AFT_BYTE_DONE;
                state         <= S_ACK;
              end else begin
                // read data: byte first, master ack after it
                bit_cnt   <= 4'h0;
                drive_low <= data_wr ? ~pwdata[7] : ~target_shift_byte[7];
                if (data_wr) begin
                  target_shift_byte <= pwdata[7:0];
                end
                state <= S_TX;
              end
            end else if (complete) begin
              if (!dir) begin
                drive_low     <= ~ack_eff;
                ack_sent_nack <= ack_eff;
                after_ack     <= `AFT_WAIT;
                state         <= S_ACK;
              end else begin
                state <= S_WAIT;
              end
            end
          end
          S_ACK: begin
            // a nack that reads back low is a clash
            if (scl_rise & ack_sent_nack & ~sda_s) begin
              tx_clash_flag <= 1'b1;
            end
            if (scl_fall) begin
              drive_low <= 1'b0;
              bit_cnt   <= 4'h0;
              if (ack_sent_nack | after_ack == `AFT_WAIT) begin
                state <= S_WAIT;
              end else if (after_ack == `AFT_BYTE_DONE) begin
                byte_done_flag <= 1'b1;
                hold_addr      <= 1'b0;
                state          <= S_HOLD;
              end else begin
                state <= S_RX;
              end
            end
          end
          S_TX: begin
            if (scl_rise & ~drive_low & ~sda_s) begin
              tx_clash_flag <= 1'b1;
            end
            if (scl_fall) begin
              if (bit_cnt == 4'h7) begin
                drive_low <= 1'b0;
                state     <= S_MACK;
              end else begin
                bit_cnt           <= bit_cnt + 4'h1;
                drive_low         <= ~target_shift_byte[6];
                target_shift_byte <= {target_shift_byte[6:0], 1'b1};
              end
            end
          end
          S_MACK: begin
            if (scl_rise) begin
              master_ack_seen <= sda_s;
            end
            if (scl_fall) begin
              // byte is done even if it clashed
              byte_done_flag <= 1'b1;
              hold_addr      <= 1'b0;
              bit_cnt        <= 4'h0;
              state          <= master_ack_seen ? S_WAIT : S_HOLD;
            end
          end
          default: begin
            drive_low <= 1'b0;
          end
        endcase
      end
    end
  end

  // read mux
  always @* begin
    prdata = 32'h0000_0000;
    if (hit_ca) begin
      prdata[7:0] = control_a;
    end else if (hit_cb) begin
      // command field always reads as zero
      prdata[7:0] = {5'h00, ack_reply_select, 2'b00};
    end else if (hit_st) begin
      prdata[7:0] = {byte_done_flag, addr_stop_flag, holding,
                     master_ack_seen, tx_clash_flag, bus_fault_flag, dir, flag_cause};
    end else if (hit_ad) begin
      prdata[7:0] = target_own_address;
    end else if (hit_dt) begin
      prdata[7:0] = target_shift_byte;
    end else if (hit_cc) begin
      prdata[7:0] = {7'h00, controller_enable};
    end
  end

endmodule

// ---- hw/twowire_target_consts.vh ----
// register indices, field positions, reset values and command codes
// of the two-wire target block; byte address of a register is 4 * index
`ifndef TWOWIRE_TARGET_CONSTS_VH
`define TWOWIRE_TARGET_CONSTS_VH

// register indices
`define IDX_CONTROL_A        8'h09
`define IDX_CONTROL_B        8'h0a
`define IDX_STATUS           8'h0b
`define IDX_OWN_ADDRESS      8'h0c
`define IDX_SHIFT_BYTE       8'h0d
`define IDX_CONTROLLER_CTL   8'h10

// target_control_a fields
`define CTLA_STOP_IRQ_EN     5
`define CTLA_PROMISC         2
`define CTLA_AUTO_RESUME     1
`define CTLA_ENABLE          0

// target_control_b fields
`define CTLB_ACK_SEL         2
`define CTLB_CMD_HI          1
`define CTLB_CMD_LO          0

// target_status fields
`define ST_BYTE_DONE         7
`define ST_ADDR_STOP         6
`define ST_STRETCH           5
`define ST_MASTER_ACK        4
`define ST_CLASH             3
`define ST_BUS_FAULT         2
`define ST_DIR               1
`define ST_CAUSE             0

// controller_control_a fields
`define CCTL_ENABLE          0

// command codes
`define CMD_NO_OP            2'h0
`define CMD_RESERVED         2'h1
`define CMD_COMPLETE         2'h2
`define CMD_RESPONSE         2'h3

// reset values
`define RST_REG8             8'h00

// after-acknowledge destinations
`define AFT_RX               2'h0
`define AFT_BYTE_DONE        2'h1
`define AFT_WAIT             2'h2

`endif

// ---- verif/twowire_controller_model.sv ----
// bus controller model: start, stop and byte transfers with acknowledge
// assumes open-drain wires with pull-ups resolved by the bench
`timescale 1ns/1ps
module twowire_controller_model (
  // wire levels
  input  wire logic scl,
  input  wire logic sda,
  // pull-low requests
  output logic      scl_lo,
  output logic      sda_lo
);
  int stuck;
  int slow;

  initial begin
    scl_lo = 1'b0;
    sda_lo = 1'b0;
    stuck = 0;
    slow = 0;
  end

  // release scl, then wait out a stretch by the target, bounded
  task automatic rise;
    int n;
    scl_lo = 1'b0;
    for (n = 0; n < 4000 && scl !== 1'b1; n++) #10;
    if (n == 4000) stuck++;
  endtask

  task automatic start_c;
    // step off the system clock edges so no wire change races a sample
    #((13 - $time % 10) % 10);
    sda_lo = 1'b0;
    #20 rise;
    #40 sda_lo = 1'b1;
    #40 scl_lo = 1'b1;
    #20;
  endtask

  task automatic stop_c;
    sda_lo = 1'b1;
    #20 rise;
    #40 sda_lo = 1'b0;
    #40;
  endtask

  // msb first, ninth clock is acknowledge; a 1 in tx leaves sda released
  task automatic xfer(input logic [7:0] tx, input logic ack_in,
                      output logic [7:0] rx, output logic ack_out);
    int i;
    for (i = 8; i >= 0; i--) begin
      sda_lo = (i > 0) ? !tx[i-1] : !ack_in;
      // low phase outlasts the target's stretch latency of up to four cycles
      #(30 + slow) rise;
      #20;
      if (i > 0) rx[i-1] = sda;
      else ack_out = sda;
      #10 scl_lo = 1'b1;
      #20;
    end
  endtask
endmodule

// ---- verif/twowire_target_bench.sv ----
// self-checking bench for the two-wire target: apb traffic plus
// controller transfers; pull-ups on both wires are modelled here
`timescale 1ns/1ps
`include "twowire_target_consts.vh"
module twowire_target_bench;
  logic        clk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  wire         scl_out;
  wire         scl_oe;
  wire         sda_out;
  wire         sda_oe;
  wire         scl_lo;
  wire         sda_lo;
  wire         scl;
  wire         sda;
  int          n_fail;
  int          cmp_count;
  logic [31:0] seed;
  logic [31:0] rd;
  logic        err;
  logic        ak;
  logic [6:0]  a7;
  logic [7:0]  rx;
  logic [7:0]  dat;
  logic [7:0]  t1;
  logic [7:0]  t2;

  assign scl = !(scl_oe || scl_lo);
  assign sda = !(sda_oe || sda_lo);

  twowire_target #(.AW(12)) dut_u (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe)
  );
  twowire_controller_model m_u (.scl(scl), .sda(sda), .scl_lo(scl_lo), .sda_lo(sda_lo));

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // status right after an address match: flag, stretch, cause, direction
  function automatic logic [31:0] addr_status(input logic rw);
    return {24'h0, 6'b011000, rw, 1'b1};
  endfunction

  task automatic close_out;
    if (n_fail == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 16) begin
      n_fail++;
      close_out;
    end
  endtask

  task automatic wait_st(input logic [7:0] mask);
    int i;
    for (i = 0; i < 3000; i++) begin
      apb(1'b0, `IDX_STATUS, 8'h00);
      if ((rd[7:0] & mask) != 8'h00) break;
    end
    if (i == 3000) begin
      n_fail++;
      close_out;
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    n_fail = 0;
    cmp_count = 0;
    seed = 32'd8482;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    for (int k = 10; k <= 12; k++) begin
      apb(1'b0, k[7:0], 8'h00);
      chk(rd, 32'h0);
    end
    repeat (4) begin
      seed = xs(seed);
      apb(1'b1, `IDX_CONTROL_B, seed[7:0]);
      apb(1'b0, `IDX_CONTROL_B, 8'h00);
      chk(rd, {29'h0, seed[2], 2'b00});
      apb(1'b1, `IDX_OWN_ADDRESS, seed[15:8]);
      apb(1'b0, `IDX_OWN_ADDRESS, 8'h00);
      chk(rd, {24'h0, seed[15:8]});
    end
    apb(1'b1, `IDX_STATUS, 8'h33);
    apb(1'b0, `IDX_STATUS, 8'h00);
    chk(rd, 32'h0);
    apb(1'b0, 8'h0f, 8'h00);
    chk({err, rd[30:0]}, 32'h8000_0000);
    seed = xs(seed);
    a7 = seed[6:0] | 7'h01;
    dat = seed[15:8];
    apb(1'b1, `IDX_OWN_ADDRESS, {a7, 1'b0});
    apb(1'b1, `IDX_CONTROL_A, 8'h21);
    apb(1'b1, `IDX_CONTROLLER_CTL, 8'h01);
    // controller writes one byte, target refuses the second acknowledge
    fork
      begin
        m_u.start_c;
        m_u.xfer({a7, 1'b0}, 1'b1, rx, ak);
        chk(ak, 0);
        m_u.xfer(dat, 1'b1, rx, ak);
        chk(ak, 1);
        m_u.stop_c;
      end
      begin
        wait_st(8'h40);
        chk(rd, addr_status(1'b0));
        apb(1'b1, `IDX_CONTROL_B, 8'h00);
        apb(1'b1, `IDX_CONTROL_B, 8'h01);
        apb(1'b0, `IDX_STATUS, 8'h00);
        chk(rd, addr_status(1'b0));
        apb(1'b1, `IDX_CONTROL_B, 8'h03);
        wait_st(8'h80);
        chk(rd, 32'ha1);
        apb(1'b0, `IDX_SHIFT_BYTE, 8'h00);
        chk(rd, {24'h0, dat});
        apb(1'b1, `IDX_CONTROL_B, 8'h06);
        wait_st(8'h40);
        chk(rd & 32'hc1, 32'h40);
        apb(1'b1, `IDX_STATUS, 8'h40);
        apb(1'b0, `IDX_STATUS, 8'h00);
        chk(rd & 32'h40, 32'h0);
      end
    join
    seed = xs(seed);
    t1 = seed[7:0];
    t2 = seed[15:8] | 8'h80;
    m_u.slow = 150;
    // slow controller reads two bytes and jams the first bit of the second
    fork
      begin
        m_u.start_c;
        m_u.xfer({a7, 1'b1}, 1'b1, rx, ak);
        chk(ak, 0);
        m_u.xfer(8'hff, 1'b0, rx, ak);
        chk(rx, t1);
        m_u.xfer(8'h7f, 1'b1, rx, ak);
        chk(rx, 32'h7f);
      end
      begin
        wait_st(8'h40);
        chk(rd, addr_status(1'b1));
        apb(1'b1, `IDX_CONTROL_B, 8'h03);
        wait_st(8'h80);
        chk(rd & 32'he2, 32'ha2);
        apb(1'b1, `IDX_SHIFT_BYTE, t1);
        apb(1'b1, `IDX_CONTROL_B, 8'h03);
        wait_st(8'h80);
        chk(rd & 32'h92, 32'h82);
        apb(1'b1, `IDX_SHIFT_BYTE, t2);
        apb(1'b1, `IDX_CONTROL_B, 8'h03);
        wait_st(8'h80);
        chk(rd & 32'h9a, 32'h9a);
      end
    join
    m_u.slow = 0;
    m_u.start_c;
    m_u.stop_c;
    repeat (10) @(posedge clk);
    apb(1'b0, `IDX_STATUS, 8'h00);
    chk(rd & 32'h0c, 32'h04);
    apb(1'b1, `IDX_STATUS, 8'hc4);
    apb(1'b0, `IDX_STATUS, 8'h00);
    chk(rd & 32'hcc, 32'h0);
    // auto-resume, accept-all, no stop flag: data reads alone release scl
    apb(1'b1, `IDX_CONTROL_A, 8'h07);
    fork
      begin
        m_u.start_c;
        m_u.xfer(~{a7, 1'b1}, 1'b1, rx, ak);
        chk(ak, 0);
        m_u.xfer(dat, 1'b1, rx, ak);
        chk(ak, 0);
        m_u.stop_c;
      end
      begin
        wait_st(8'h40);
        apb(1'b0, `IDX_SHIFT_BYTE, 8'h00);
        chk(rd, {24'h0, ~{a7, 1'b1}});
        wait_st(8'h80);
        apb(1'b0, `IDX_SHIFT_BYTE, 8'h00);
        chk(rd, {24'h0, dat});
      end
    join
    repeat (10) @(posedge clk);
    apb(1'b0, `IDX_STATUS, 8'h00);
    chk(rd & 32'hc4, 32'h0);
    chk(m_u.stuck, 0);
    close_out;
  end
endmodule

// ---- verif/twowire_target_monitor.sv ----
// assertion checker for the two-wire target, watching its top ports only
// assumes one clock domain; attached by the bind at the foot
`timescale 1ns/1ps
`include "twowire_target_consts.vh"
module twowire_target_monitor #(
  parameter AW = 12
) (
  // clock and reset
  input wire logic          clk,
  input wire logic          rst_n,
  // apb
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0]   pwdata,
  input wire logic [31:0]   prdata,
  input wire logic          pready,
  input wire logic          pslverr,
  // two-wire pins
  input wire logic          scl_in,
  input wire logic          scl_out,
  input wire logic          scl_oe,
  input wire logic          sda_in,
  input wire logic          sda_out,
  input wire logic          sda_oe
);
  logic          acc;
  logic          ok_a;
  logic          wr_b;
  logic          rd_b;
  logic          rd_s;
  logic          ack_sh;
  logic [AW-3:0] ix;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  assign ix   = paddr[AW-1:2];
  assign acc  = psel && penable;
  assign ok_a = paddr[1:0] == 2'b00 && ix inside {`IDX_CONTROL_A, `IDX_CONTROL_B,
                `IDX_STATUS, `IDX_OWN_ADDRESS, `IDX_SHIFT_BYTE, `IDX_CONTROLLER_CTL};
  assign wr_b = acc && pwrite && ok_a && ix == `IDX_CONTROL_B;
  assign rd_b = acc && !pwrite && ok_a && ix == `IDX_CONTROL_B;
  assign rd_s = acc && !pwrite && ok_a && ix == `IDX_STATUS;

  // last written ack choice, what software expects to read back
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n) ack_sh <= 1'b0;
    else if (wr_b) ack_sh <= pwdata[`CTLB_ACK_SEL];

  ready_always_a: assert property (pready)
    else $error("pready low");
  unmapped_err_a: assert property (acc && !ok_a |-> pslverr)
    else $error("unmapped access without error");
  cmd_zero_a: assert property (rd_b |-> prdata[1:0] == 2'b00)
    else $error("command field reads nonzero");
  ack_store_a: assert property (rd_b |-> prdata[2] == ack_sh)
    else $error("ack choice not kept");
  clash_quiet_a: assert property (rd_s && prdata[`ST_CLASH] |-> !sda_oe)
    else $error("sda driven after collision");
  noop_hold_a: assert property (wr_b && pwdata[1:0] == `CMD_NO_OP && scl_oe |=> scl_oe [*4])
    else $error("no-op command released scl");
  reserved_hold_a: assert property (wr_b && pwdata[1:0] == `CMD_RESERVED && scl_oe
    |=> (scl_oe && $stable(sda_oe)) [*4]) else $error("reserved command acted");
  resume_release_a: assert property (wr_b && pwdata[1] && scl_oe |-> ##[1:4] !scl_oe)
    else $error("command did not release scl");
  open_drain_a: assert property (scl_out == 1'b0 && sda_out == 1'b0)
    else $error("pin drives high");
endmodule

bind twowire_target twowire_target_monitor #(.AW(AW)) mon_u (
  .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe)
);
